// file: rtl/acdp_aux_control.sv
// Overview of operation
// - Writing aux_control with bit 3 set resets all registers and both pointers but keeps the customer area, restarting at 0000.
// - pointer_select_bit chooses which of two data pointers every pointer instruction uses.
// - The unselected data pointer is unreachable until the select bit changes.
// - Pointer increment adds one to the selected pointer only.
// - Immediate load writes the 16-bit constant into the selected pointer only.
// - Indirect jump target is accumulator plus selected pointer.
// - Code byte read fetches byte at accumulator plus selected pointer.
// - External data moves, read and write, address with the selected pointer.
// - Pointer high and low byte accesses act on the selected pointer.
// - Bit 2 of aux_control reads zero and ignores writes.
// - No external bus; external moves only read on-chip configuration.
// - Signature bytes return at code addresses FC30h, FC31h, FC60h.
// - Customer data area of 32 bytes readable from FCE0h to FCFFh.
// - First user config byte readable by external move read at FD00h.
`timescale 1ns/1ns
`default_nettype none
`include "acdp_defs.svh"

module acdp_aux_control
    import acdp_pkg::*;
#(
    parameter logic [7:0] SIG0_VALUE = 8'h11,  // Arbitrary value
    parameter logic [7:0] SIG1_VALUE = 8'h22,  // Arbitrary value
    parameter logic [7:0] SIG2_VALUE = 8'h33,  // Arbitrary value
    parameter int         CUST_DEPTH = 32
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata_q,
    input  wire acdp_op_t    op,
    input  wire logic [7:0]  acc,
    input  wire logic [15:0] imm16,
    input  wire logic [7:0]  cfg1_byte,
    input  wire logic        cust_wr,
    input  wire logic [4:0]  cust_waddr,
    input  wire logic [7:0]  cust_wdata,
    output logic      [15:0] jump_target_q,
    output logic             jump_valid_q,
    output logic      [15:0] xdata_addr_q,
    output logic      [7:0]  read_data_q,
    output logic             read_valid_q,
    output logic             chip_reset_q
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0]  aux_q;
    logic [15:0] ptr_q [2];
    logic [7:0]  cust_mem [CUST_DEPTH];
    logic        sel;
    logic [15:0] cur_ptr;
    logic        aux_wr;
    logic        sync_rst;

    function automatic logic [7:0] code_byte(input logic [15:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == `ACDP_SIG0_ADDR)
            r = SIG0_VALUE;
        else if (a == `ACDP_SIG1_ADDR)
            r = SIG1_VALUE;
        else if (a == `ACDP_SIG2_ADDR)
            r = SIG2_VALUE;
        else if (a >= `ACDP_CUST_BASE && a <= `ACDP_CUST_LAST)
            r = cust_mem[a[4:0]];
        return r;
    endfunction

    assign sel      = aux_q[`ACDP_SELECT_BIT];
    assign cur_ptr  = ptr_q[sel];
    assign aux_wr   = bus_wr && bus_addr == `ACDP_AUX_CONTROL_ADDR;
    assign sync_rst = !rst_n || chip_reset_q;

    // ****************************************
    // Aux control register
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (sync_rst)
            aux_q <= `ACDP_AUX_CONTROL_RESET;
        else if (aux_wr)
        begin
            aux_q <= bus_wdata;
            aux_q[`ACDP_ZERO_BIT] <= 1'b0;
        end
    end

    // Soft reset pulse, one cycle, self clearing
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            chip_reset_q <= 1'b0;
        else
            chip_reset_q <= aux_wr && bus_wdata[`ACDP_SOFT_RESET_BIT]
                            && !chip_reset_q;
    end

    // ****************************************
    // Dual data pointers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (sync_rst)
        begin
            ptr_q[0] <= 16'h0000;
            ptr_q[1] <= 16'h0000;
        end
        else if (op == ACDP_OP_INC)
            ptr_q[sel] <= cur_ptr + 16'h0001;
        else if (op == ACDP_OP_LOAD)
            ptr_q[sel] <= imm16;
        else if (bus_wr && bus_addr == `ACDP_PTR_LOW_ADDR)
            ptr_q[sel][7:0] <= bus_wdata;
        else if (bus_wr && bus_addr == `ACDP_PTR_HIGH_ADDR)
            ptr_q[sel][15:8] <= bus_wdata;
    end

    // Customer area load path; never an instruction source
    always_ff @(posedge ref_clk)
    begin
        if (cust_wr)
            cust_mem[cust_waddr] <= cust_wdata;
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (sync_rst)
            bus_rdata_q <= 8'h00;
        else if (bus_rd)
        begin
            unique case (bus_addr)
                `ACDP_AUX_CONTROL_ADDR: bus_rdata_q <= aux_q;
                `ACDP_PTR_LOW_ADDR:     bus_rdata_q <= cur_ptr[7:0];
                `ACDP_PTR_HIGH_ADDR:    bus_rdata_q <= cur_ptr[15:8];
                default:                bus_rdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Pointer-based instruction effects
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (sync_rst)
        begin
            jump_target_q <= `ACDP_RESTART_ADDR;
            jump_valid_q  <= 1'b0;
            xdata_addr_q  <= 16'h0000;
            read_data_q   <= 8'h00;
            read_valid_q  <= 1'b0;
        end
        else
        begin
            jump_valid_q <= op == ACDP_OP_JMP;
            read_valid_q <= op == ACDP_OP_CODE_READ || op == ACDP_OP_XDATA_READ;
            if (op == ACDP_OP_JMP)
                jump_target_q <= cur_ptr + {8'h00, acc};
            if (op == ACDP_OP_CODE_READ)
                read_data_q <= code_byte(cur_ptr + {8'h00, acc});
            if (op == ACDP_OP_XDATA_READ || op == ACDP_OP_XDATA_WRITE)
                xdata_addr_q <= cur_ptr;
            if (op == ACDP_OP_XDATA_READ)
                read_data_q <= (cur_ptr == `ACDP_CFG1_ADDR) ? cfg1_byte
                                                            : 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_reset_write;
        aux_wr && bus_wdata[`ACDP_SOFT_RESET_BIT] && !chip_reset_q;
    endsequence
    sequence s_cleared;
        chip_reset_q ##1 (aux_q == 8'h00);
    endsequence

    property p_soft_reset;
        @(posedge ref_clk) disable iff (!rst_n)
        s_reset_write |=> s_cleared;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed");

    property p_zero_bit;
        @(posedge ref_clk) disable iff (!rst_n)
        aux_q[`ACDP_ZERO_BIT] == 1'b0;
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("bit 2 not zero");

    property p_inc;
        @(posedge ref_clk) disable iff (sync_rst)
        op == ACDP_OP_INC |=> ptr_q[$past(sel)] == $past(cur_ptr) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");

    property p_other_kept;
        @(posedge ref_clk) disable iff (sync_rst)
        (op == ACDP_OP_INC || op == ACDP_OP_LOAD) |=> ptr_q[!$past(sel)] == $past(ptr_q[!sel]);
    endproperty
    a_other_kept: assert property (p_other_kept) else $error("other pointer changed");

    property p_load;
        @(posedge ref_clk) disable iff (sync_rst)
        op == ACDP_OP_LOAD |=> ptr_q[$past(sel)] == $past(imm16);
    endproperty
    a_load: assert property (p_load) else $error("load wrong");

    property p_jump;
        @(posedge ref_clk) disable iff (sync_rst)
        op == ACDP_OP_JMP |=> jump_valid_q && jump_target_q == $past(cur_ptr) + {8'h00, $past(acc)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_xaddr;
        @(posedge ref_clk) disable iff (sync_rst)
        op == ACDP_OP_XDATA_WRITE |=> xdata_addr_q == $past(cur_ptr);
    endproperty
    a_xaddr: assert property (p_xaddr) else $error("xdata address wrong");

    property p_cfg1;
        @(posedge ref_clk) disable iff (sync_rst)
        op == ACDP_OP_XDATA_READ && cur_ptr == `ACDP_CFG1_ADDR
            |=> read_valid_q && read_data_q == $past(cfg1_byte);
    endproperty
    a_cfg1: assert property (p_cfg1) else $error("config byte read wrong");

    property p_sig0;
        @(posedge ref_clk) disable iff (sync_rst)
        op == ACDP_OP_CODE_READ && cur_ptr + {8'h00, acc} == `ACDP_SIG0_ADDR
            |=> read_data_q == SIG0_VALUE;
    endproperty
    a_sig0: assert property (p_sig0) else $error("signature read wrong");

    property p_low_byte_read;
        @(posedge ref_clk) disable iff (sync_rst)
        bus_rd && bus_addr == `ACDP_PTR_LOW_ADDR |=> bus_rdata_q == $past(cur_ptr[7:0]);
    endproperty
    a_low_byte_read: assert property (p_low_byte_read) else $error("low byte read wrong");

endmodule
`default_nettype wire

// file: rtl/acdp_defs.svh
`ifndef ACDP_DEFS_SVH
`define ACDP_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define ACDP_AUX_CONTROL_ADDR   8'ha2
`define ACDP_AUX_CONTROL_RESET  8'h00
`define ACDP_PTR_LOW_ADDR       8'h82
`define ACDP_PTR_HIGH_ADDR      8'h83

// ****************************************
// Field positions
// ****************************************
`define ACDP_SELECT_BIT         0
`define ACDP_RSVD_BIT           1
`define ACDP_ZERO_BIT           2
`define ACDP_SOFT_RESET_BIT     3

// ****************************************
// Code and data space map
// ****************************************
`define ACDP_SIG0_ADDR          16'hfc30
`define ACDP_SIG1_ADDR          16'hfc31
`define ACDP_SIG2_ADDR          16'hfc60
`define ACDP_CUST_BASE          16'hfce0
`define ACDP_CUST_LAST          16'hfcff
`define ACDP_CFG1_ADDR          16'hfd00
`define ACDP_RESTART_ADDR       16'h0000

`endif

// file: rtl/acdp_pkg.sv
package acdp_pkg;
    typedef enum logic [2:0]
    {
        ACDP_OP_NONE,
        ACDP_OP_INC,
        ACDP_OP_LOAD,
        ACDP_OP_JMP,
        ACDP_OP_CODE_READ,
        ACDP_OP_XDATA_READ,
        ACDP_OP_XDATA_WRITE
    } acdp_op_t;
endpackage

// file: test/acdp_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "acdp_defs.svh"

module acdp_cpu_model
    import acdp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        chip_reset_q,
    input  wire logic        jump_valid_q,
    input  wire logic [15:0] jump_target_q,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic      [7:0]  bus_addr,
    output logic      [7:0]  bus_wdata,
    output acdp_op_t         op,
    output logic      [7:0]  acc,
    output logic      [15:0] imm16,
    output logic      [7:0]  cfg1_byte,
    output logic             cust_wr,
    output logic      [4:0]  cust_waddr,
    output logic      [7:0]  cust_wdata,
    output logic      [15:0] pc_q
);
    initial
    begin
        {bus_wr, bus_rd, cust_wr, bus_addr, bus_wdata, acc, imm16} = '0;
        {cust_waddr, cust_wdata} = '0;
        op = ACDP_OP_NONE;
        cfg1_byte = 8'h5a;
    end

    // Restart at zero, never run from the customer area
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || chip_reset_q)
            pc_q <= `ACDP_RESTART_ADDR;
        else if (jump_valid_q && (jump_target_q < `ACDP_CUST_BASE
                 || jump_target_q > `ACDP_CUST_LAST))
            pc_q <= jump_target_q;
    end

    // Each task idles one edge first, so a strobe never toggles twice in a step
    task automatic bus_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        bus_wr = wr;
        bus_rd = !wr;
        bus_addr = a;
        bus_wdata = (a == `ACDP_AUX_CONTROL_ADDR) ? (d & 8'hfd) : d;
        @(negedge ref_clk);
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask

    task automatic do_op(input acdp_op_t o, input logic [7:0] a, input logic [15:0] i);
        @(negedge ref_clk);
        op = o;
        acc = a;
        imm16 = i;
        @(negedge ref_clk);
        op = ACDP_OP_NONE;
        acc = ~a;
        imm16 = ~i;
    endtask

    task automatic cust_load(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cust_wr = 1'b1;
        cust_waddr = a;
        cust_wdata = d;
        @(negedge ref_clk);
        cust_wr = 1'b0;
        cust_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// file: test/aux_control_dual_pointer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "acdp_defs.svh"

module aux_control_dual_pointer_tb
    import acdp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_wr, bus_rd, cust_wr, jump_valid_q, read_valid_q, chip_reset_q;
    logic [7:0] bus_addr, bus_wdata, bus_rdata_q, acc, cfg1_byte, cust_wdata, read_data_q;
    logic [15:0] imm16, jump_target_q, xdata_addr_q, pc_q;
    logic [4:0] cust_waddr;
    acdp_op_t op;
    int fail_count = 0;
    int compares = 0;
    logic [15:0] tp[6] = '{16'hfc30, 16'hfc30, 16'hfc60, 16'hfcc0, 16'hfce0, 16'hfce0};
    logic [7:0] ta[6] = '{8'h00, 8'h01, 8'h00, 8'h1f, 8'h00, 8'h1f};
    logic [7:0] te[6] = '{8'h4c, 8'h9d, 8'h3e, 8'h00, 8'ha5, 8'hba};

    always #5 ref_clk = ~ref_clk;

    acdp_aux_control #(
        .SIG0_VALUE    (8'h4c),
        .SIG1_VALUE    (8'h9d),
        .SIG2_VALUE    (8'h3e),
        .CUST_DEPTH    (32)
    ) i_dut (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .bus_wr        (bus_wr),
        .bus_rd        (bus_rd),
        .bus_addr      (bus_addr),
        .bus_wdata     (bus_wdata),
        .bus_rdata_q   (bus_rdata_q),
        .op            (op),
        .acc           (acc),
        .imm16         (imm16),
        .cfg1_byte     (cfg1_byte),
        .cust_wr       (cust_wr),
        .cust_waddr    (cust_waddr),
        .cust_wdata    (cust_wdata),
        .jump_target_q (jump_target_q),
        .jump_valid_q  (jump_valid_q),
        .xdata_addr_q  (xdata_addr_q),
        .read_data_q   (read_data_q),
        .read_valid_q  (read_valid_q),
        .chip_reset_q  (chip_reset_q)
    );
    acdp_cpu_model i_cpu (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .chip_reset_q  (chip_reset_q),
        .jump_valid_q  (jump_valid_q),
        .jump_target_q (jump_target_q),
        .bus_wr        (bus_wr),
        .bus_rd        (bus_rd),
        .bus_addr      (bus_addr),
        .bus_wdata     (bus_wdata),
        .op            (op),
        .acc           (acc),
        .imm16         (imm16),
        .cfg1_byte     (cfg1_byte),
        .cust_wr       (cust_wr),
        .cust_waddr    (cust_waddr),
        .cust_wdata    (cust_wdata),
        .pc_q          (pc_q)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string n, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_cpu.bus_access(1'b0, a, 8'h00);
        check("bus_rdata_q", 16'(bus_rdata_q), 16'(e));
    endtask

    task automatic ptr(input logic [15:0] e);
        rd(`ACDP_PTR_LOW_ADDR, e[7:0]);
        rd(`ACDP_PTR_HIGH_ADDR, e[15:8]);
    endtask

    task automatic sel(input logic b);
        i_cpu.bus_access(1'b1, `ACDP_AUX_CONTROL_ADDR, {7'h00, b});
    endtask

    task automatic opr(input acdp_op_t o, input logic [7:0] a, input logic [7:0] e);
        i_cpu.do_op(o, a, 16'h0000);
        check("read_valid_q", 16'(read_valid_q), 16'h0001);
        check("read_data_q", 16'(read_data_q), 16'(e));
    endtask

    initial
    begin
        #50000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        rd(`ACDP_AUX_CONTROL_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        i_cpu.bus_access(1'b1, `ACDP_AUX_CONTROL_ADDR, 8'h05);
        rd(`ACDP_AUX_CONTROL_ADDR, 8'h01);
        i_cpu.do_op(ACDP_OP_LOAD, 8'h00, 16'h1234);
        sel(1'b0);
        i_cpu.do_op(ACDP_OP_LOAD, 8'h00, 16'hfce0);
        ptr(16'hfce0);
        sel(1'b1);
        ptr(16'h1234);
        i_cpu.do_op(ACDP_OP_INC, 8'h00, 16'h0000);
        ptr(16'h1235);
        i_cpu.do_op(ACDP_OP_JMP, 8'h10, 16'h0000);
        check("jump_valid_q", 16'(jump_valid_q), 16'h0001);
        check("jump_target_q", jump_target_q, 16'h1245);
        i_cpu.bus_access(1'b1, `ACDP_PTR_LOW_ADDR, 8'hff);
        i_cpu.do_op(ACDP_OP_INC, 8'h00, 16'h0000);
        ptr(16'h1300);
        i_cpu.bus_access(1'b1, `ACDP_PTR_HIGH_ADDR, 8'h56);
        ptr(16'h5600);
        sel(1'b0);
        ptr(16'hfce0);
        for (int i = 0; i < 32; i++)
            i_cpu.cust_load(5'(i), 8'ha5 ^ 8'(i));
        for (int i = 0; i < 6; i++)
        begin
            i_cpu.do_op(ACDP_OP_LOAD, 8'h00, tp[i]);
            opr(ACDP_OP_CODE_READ, ta[i], te[i]);
        end
        i_cpu.do_op(ACDP_OP_LOAD, 8'h00, `ACDP_CFG1_ADDR);
        opr(ACDP_OP_XDATA_READ, 8'h00, 8'h5a);
        check("xdata_addr_q", xdata_addr_q, 16'hfd00);
        i_cpu.do_op(ACDP_OP_INC, 8'h00, 16'h0000);
        opr(ACDP_OP_XDATA_READ, 8'h00, 8'h00);
        i_cpu.do_op(ACDP_OP_XDATA_WRITE, 8'h00, 16'h0000);
        check("xdata_addr_q", xdata_addr_q, 16'hfd01);
        sel(1'b1);
        i_cpu.bus_access(1'b1, `ACDP_AUX_CONTROL_ADDR, 8'h09);
        check("chip_reset_q", 16'(chip_reset_q), 16'h0001);
        @(negedge ref_clk);
        check("chip_reset_q", 16'(chip_reset_q), 16'h0000);
        check("pc_q", pc_q, 16'h0000);
        check("jump_target_q", jump_target_q, `ACDP_RESTART_ADDR);
        rd(`ACDP_AUX_CONTROL_ADDR, 8'h00);
        ptr(16'h0000);
        sel(1'b1);
        ptr(16'h0000);
        stop_test();
    end
endmodule

`default_nettype wire
